// ---- verilog/pcc_defines.svh ----
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH

// Register byte offsets.
`define PCC_CTRL_OFS 8'h00
`define PCC_CLKSRC_OFS 8'h04
`define PCC_PSC_BASE 8'h08
`define PCC_PER_BASE 8'h14
`define PCC_CNT_BASE 8'h20
`define PCC_CMP_BASE 8'h30
`define PCC_OUT_OFS 8'h48
`define PCC_CAPCTL_OFS 8'h4c
`define PCC_CAP_BASE 8'h50
`define PCC_TRIG_OFS 8'h68

// Field positions.
`define PCC_EN_LSB 0
`define PCC_CTYPE_LSB 4
`define PCC_COMP_LSB 12
`define PCC_CLKHALF_BIT 16
`define PCC_SRC_STRIDE 8
`define PCC_DIR_BIT 16
`define PCC_POL_LSB 0
`define PCC_MSKEN_LSB 8
`define PCC_MSKDAT_LSB 16
`define PCC_OE_LSB 24
`define PCC_BRAKEEN_BIT 30
`define PCC_CAPEN_LSB 0
`define PCC_CAPRISE_LSB 8
`define PCC_CAPFALL_LSB 16
`define PCC_TZERO_LSB 0
`define PCC_TPER_LSB 4
`define PCC_TCMP_LSB 8
`define PCC_TADC_LSB 16

// Reset values.
`define PCC_PER_RST 16'hffff
`define PCC_CMP_RST 16'h0000
`define PCC_PSC_RST 12'h000
`define PCC_SRC_RST 3'h0

`endif

// ---- verilog/pcc_pkg.sv ----
package pcc_pkg;

  typedef enum logic [1:0] {
    PCC_UP = 2'h0,
    PCC_DOWN = 2'h1,
    PCC_UPDOWN = 2'h2
  } pcc_count_type_t;

  typedef struct packed {
    logic zero;
    logic period;
    logic center;
  } pcc_pair_evt_t;

endpackage

// ---- verilog/pwm_counter_compare_core.sv ----
// Contract
// - Counter advances every prescale plus one ticks.
// - Sixteen-bit counters and sixteen-bit compare values.
// - Up, down and up-down counting selectable.
// - Up count: zero to period, period+1 clocks.
// - Up count: zero and period events.
// - Down count: period to zero, period+1 clocks.
// - Down count: zero and period events.
// - Up-down: zero, period, zero; 2*period clocks.
// - Up-down: zero event and center event.
// - Direction flag at counter bit 16.
// - Counter value readable any time.
// - Per-channel compare value raises match events.
// - Up-down: compare matches up and down.
// - Channel pairs share one counter always.
// - Six channels driven by three counters.
// - Complementary: even channel uses odd comparator.
// - Per-pair clock source select fields.
// - Module clock equals or doubles bus clock.
// - Interrupt and converter triggers on events.
// - Capture counter on chosen input edges.
// - Polarity, mask, output enable, brake.
// - Period and compare reload at cycle end.
`include "pcc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module pwm_counter_compare_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdData,
  input wire logic [3:0] timerTrig,
  input wire logic [5:0] capIn,
  input wire logic brakeIn,
  output logic [5:0] pwmOut,
  output logic [5:0] pwmOe,
  output logic [5:0] cmpUpEvt,
  output logic [5:0] cmpDnEvt,
  output pcc_pkg::pcc_pair_evt_t [2:0] pairEvt,
  output logic [2:0] intReq,
  output logic [2:0] adcTrig
);

  logic [2:0] enQ;
  pcc_pkg::pcc_count_type_t ctypeQ [3];
  logic [2:0] compQ;
  logic clkHalfQ;
  logic halfQ;
  logic [2:0] srcSelQ [3];
  logic [11:0] pscValQ [3];
  logic [11:0] pscCntQ [3];
  logic [15:0] perShQ [3];
  logic [15:0] perBufQ [3];
  logic [15:0] cntQ [3];
  logic [2:0] dirQ;
  logic [15:0] cmpShQ [6];
  logic [15:0] cmpBufQ [6];
  logic [5:0] polQ;
  logic [5:0] mskEnQ;
  logic [5:0] mskDatQ;
  logic [5:0] oeQ;
  logic brakeEnQ;
  logic [5:0] capEnQ;
  logic [5:0] capRiseQ;
  logic [5:0] capFallQ;
  logic [5:0] capPrevQ;
  logic [15:0] capQ [6];
  logic [15:0] trigEnQ;
  logic [15:0] adcEnQ;
  logic [5:0] rawQ;

  logic sysTick;
  logic [2:0] pairTick;
  logic [2:0] pairLoad;
  logic [2:0] zeroHit;
  logic [2:0] perHit;
  logic [2:0] ctrHit;
  logic [15:0] cntNext [3];
  logic [2:0] dirNext;
  logic [5:0] hitUp;
  logic [5:0] hitDn;
  logic [31:0] rdVal;

  // When the module clock runs at twice the bus clock, the system source
  // ticks on every other cycle; at the 1/1 ratio it ticks every cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      halfQ <= 1'b0;
    end else begin
      halfQ <= ~halfQ;
    end
  end
  assign sysTick = ~clkHalfQ | halfQ;

  always_ff @(posedge clk) begin
    if (rst) begin
      enQ <= 3'h0;
      compQ <= 3'h0;
      clkHalfQ <= 1'b0;
      polQ <= 6'h00;
      mskEnQ <= 6'h00;
      mskDatQ <= 6'h00;
      oeQ <= 6'h00;
      brakeEnQ <= 1'b0;
      capEnQ <= 6'h00;
      capRiseQ <= 6'h00;
      capFallQ <= 6'h00;
      trigEnQ <= 16'h0000;
      adcEnQ <= 16'h0000;
      for (int p = 0; p < 3; p++) begin
        ctypeQ[p] <= pcc_pkg::PCC_UP;
        srcSelQ[p] <= `PCC_SRC_RST;
        pscValQ[p] <= `PCC_PSC_RST;
        perShQ[p] <= `PCC_PER_RST;
      end
      for (int c = 0; c < 6; c++) begin
        cmpShQ[c] <= `PCC_CMP_RST;
      end
    end else if (wrEn) begin
      if (addr == `PCC_CTRL_OFS) begin
        enQ <= wrData[`PCC_EN_LSB +: 3];
        compQ <= wrData[`PCC_COMP_LSB +: 3];
        clkHalfQ <= wrData[`PCC_CLKHALF_BIT];
        for (int p = 0; p < 3; p++) begin
          ctypeQ[p] <= pcc_pkg::pcc_count_type_t'(wrData[`PCC_CTYPE_LSB + 2 * p +: 2]);
        end
      end
      if (addr == `PCC_CLKSRC_OFS) begin
        for (int p = 0; p < 3; p++) begin
          srcSelQ[p] <= wrData[`PCC_SRC_STRIDE * p +: 3];
        end
      end
      if (addr == `PCC_OUT_OFS) begin
        polQ <= wrData[`PCC_POL_LSB +: 6];
        mskEnQ <= wrData[`PCC_MSKEN_LSB +: 6];
        mskDatQ <= wrData[`PCC_MSKDAT_LSB +: 6];
        oeQ <= wrData[`PCC_OE_LSB +: 6];
        brakeEnQ <= wrData[`PCC_BRAKEEN_BIT];
      end
      if (addr == `PCC_CAPCTL_OFS) begin
        capEnQ <= wrData[`PCC_CAPEN_LSB +: 6];
        capRiseQ <= wrData[`PCC_CAPRISE_LSB +: 6];
        capFallQ <= wrData[`PCC_CAPFALL_LSB +: 6];
      end
      if (addr == `PCC_TRIG_OFS) begin
        trigEnQ <= wrData[15:0];
        adcEnQ <= wrData[31:16];
      end
      for (int p = 0; p < 3; p++) begin
        if (addr == 8'(`PCC_PSC_BASE + 4 * p)) begin
          pscValQ[p] <= wrData[11:0];
        end
        if (addr == 8'(`PCC_PER_BASE + 4 * p)) begin
          perShQ[p] <= wrData[15:0];
        end
      end
      for (int c = 0; c < 6; c++) begin
        if (addr == 8'(`PCC_CMP_BASE + 4 * c)) begin
          cmpShQ[c] <= wrData[15:0];
        end
      end
    end
  end

  // Three counters, each shared by two channels.
  for (genvar p = 0; p < 3; p++) begin : g_pair
    logic srcTick;

    always_comb begin
      case (srcSelQ[p])
        3'h0: srcTick = sysTick;
        3'h1: srcTick = timerTrig[0];
        3'h2: srcTick = timerTrig[1];
        3'h3: srcTick = timerTrig[2];
        3'h4: srcTick = timerTrig[3];
        default: srcTick = 1'b0;
      endcase
    end

    // A prescale value lowered below the running count still wraps at once.
    assign pairTick[p] = enQ[p] & srcTick & (pscCntQ[p] >= pscValQ[p]);

    always_comb begin
      cntNext[p] = cntQ[p];
      dirNext[p] = dirQ[p];
      pairLoad[p] = 1'b0;
      case (ctypeQ[p])
        pcc_pkg::PCC_DOWN: begin
          dirNext[p] = 1'b0;
          if (cntQ[p] == 16'h0000) begin
            cntNext[p] = perShQ[p];
            pairLoad[p] = 1'b1;
          end else begin
            cntNext[p] = cntQ[p] - 16'h0001;
          end
        end
        pcc_pkg::PCC_UPDOWN: begin
          if (dirQ[p] && cntQ[p] < perBufQ[p]) begin
            cntNext[p] = cntQ[p] + 16'h0001;
          end else if (dirQ[p] && cntQ[p] != 16'h0000) begin
            dirNext[p] = 1'b0;
            cntNext[p] = cntQ[p] - 16'h0001;
          end else if (!dirQ[p] && cntQ[p] > 16'h0001) begin
            cntNext[p] = cntQ[p] - 16'h0001;
          end else begin
            cntNext[p] = 16'h0000;
            dirNext[p] = 1'b1;
            pairLoad[p] = 1'b1;
          end
        end
        default: begin
          dirNext[p] = 1'b1;
          if (cntQ[p] >= perBufQ[p]) begin
            cntNext[p] = 16'h0000;
            pairLoad[p] = 1'b1;
          end else begin
            cntNext[p] = cntQ[p] + 16'h0001;
          end
        end
      endcase
    end

    logic [15:0] perNext;
    assign perNext = pairLoad[p] ? perShQ[p] : perBufQ[p];
    assign zeroHit[p] = pairTick[p] & (cntNext[p] == 16'h0000);
    assign perHit[p] = pairTick[p] & (ctypeQ[p] != pcc_pkg::PCC_UPDOWN) & (cntNext[p] == perNext);
    assign ctrHit[p] = pairTick[p] & (ctypeQ[p] == pcc_pkg::PCC_UPDOWN) & (cntNext[p] == perNext);

    always_ff @(posedge clk) begin
      if (rst) begin
        pscCntQ[p] <= 12'h000;
        cntQ[p] <= 16'h0000;
        dirQ[p] <= 1'b1;
        perBufQ[p] <= `PCC_PER_RST;
      end else if (!enQ[p]) begin
        // A stopped counter sits at its start value with buffers tracking
        // software, so the first cycle after enable uses fresh values.
        pscCntQ[p] <= 12'h000;
        cntQ[p] <= (ctypeQ[p] == pcc_pkg::PCC_DOWN) ? perShQ[p] : 16'h0000;
        dirQ[p] <= (ctypeQ[p] != pcc_pkg::PCC_DOWN);
        perBufQ[p] <= perShQ[p];
      end else begin
        if (srcTick) begin
          pscCntQ[p] <= pairTick[p] ? 12'h000 : pscCntQ[p] + 12'h001;
        end
        if (pairTick[p]) begin
          cntQ[p] <= cntNext[p];
          dirQ[p] <= dirNext[p];
          if (pairLoad[p]) begin
            perBufQ[p] <= perShQ[p];
          end
        end
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        pairEvt[p] <= '0;
        intReq[p] <= 1'b0;
        adcTrig[p] <= 1'b0;
      end else begin
        pairEvt[p].zero <= zeroHit[p];
        pairEvt[p].period <= perHit[p];
        pairEvt[p].center <= ctrHit[p];
        intReq[p] <= (zeroHit[p] & trigEnQ[`PCC_TZERO_LSB + p])
                   | ((perHit[p] | ctrHit[p]) & trigEnQ[`PCC_TPER_LSB + p])
                   | (|((hitUp[2*p +: 2] | hitDn[2*p +: 2]) & trigEnQ[`PCC_TCMP_LSB + 2*p +: 2]));
        adcTrig[p] <= (zeroHit[p] & adcEnQ[`PCC_TZERO_LSB + p])
                    | ((perHit[p] | ctrHit[p]) & adcEnQ[`PCC_TPER_LSB + p])
                    | (|((hitUp[2*p +: 2] | hitDn[2*p +: 2]) & adcEnQ[`PCC_TCMP_LSB + 2*p +: 2]));
      end
    end
  end

  for (genvar c = 0; c < 6; c++) begin : g_chan
    localparam int PR = c / 2;
    localparam int ODD = c | 1;
    logic [15:0] cmpSel;

    assign cmpSel = (compQ[PR] && (c % 2 == 0)) ? cmpBufQ[ODD] : cmpBufQ[c];
    assign hitUp[c] = pairTick[PR] & dirNext[PR] & (cntNext[PR] == cmpSel);
    assign hitDn[c] = pairTick[PR] & ~dirNext[PR] & (cntNext[PR] == cmpSel);

    always_ff @(posedge clk) begin
      if (rst) begin
        cmpBufQ[c] <= `PCC_CMP_RST;
      end else if (!enQ[PR] || (pairTick[PR] && pairLoad[PR])) begin
        cmpBufQ[c] <= cmpShQ[c];
      end
    end

    // A compare hit outranks the cycle-boundary event, which gives clean
    // 0% and 100% duty at the extreme compare values.
    always_ff @(posedge clk) begin
      if (rst || !enQ[PR]) begin
        rawQ[c] <= 1'b0;
      end else if (ctypeQ[PR] == pcc_pkg::PCC_DOWN) begin
        if (hitDn[c]) begin
          rawQ[c] <= 1'b1;
        end else if (perHit[PR]) begin
          rawQ[c] <= 1'b0;
        end
      end else if (hitUp[c]) begin
        rawQ[c] <= 1'b0;
      end else if (hitDn[c] || zeroHit[PR]) begin
        rawQ[c] <= 1'b1;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        cmpUpEvt[c] <= 1'b0;
        cmpDnEvt[c] <= 1'b0;
        pwmOut[c] <= 1'b0;
        pwmOe[c] <= 1'b0;
      end else begin
        cmpUpEvt[c] <= hitUp[c];
        cmpDnEvt[c] <= hitDn[c];
        if (brakeEnQ && brakeIn) begin
          pwmOut[c] <= 1'b0;
        end else if (mskEnQ[c]) begin
          pwmOut[c] <= mskDatQ[c];
        end else begin
          pwmOut[c] <= rawQ[c] ^ polQ[c];
        end
        pwmOe[c] <= oeQ[c] & ~(brakeEnQ & brakeIn);
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        capPrevQ[c] <= 1'b0;
        capQ[c] <= 16'h0000;
      end else begin
        capPrevQ[c] <= capIn[c];
        if (capEnQ[c] && ((capRiseQ[c] && capIn[c] && !capPrevQ[c])
            || (capFallQ[c] && !capIn[c] && capPrevQ[c]))) begin
          capQ[c] <= cntQ[PR];
        end
      end
    end
  end

  always_comb begin
    rdVal = 32'h0000_0000;
    if (addr == `PCC_CTRL_OFS) begin
      rdVal[`PCC_EN_LSB +: 3] = enQ;
      rdVal[`PCC_COMP_LSB +: 3] = compQ;
      rdVal[`PCC_CLKHALF_BIT] = clkHalfQ;
      for (int p = 0; p < 3; p++) begin
        rdVal[`PCC_CTYPE_LSB + 2 * p +: 2] = ctypeQ[p];
      end
    end
    if (addr == `PCC_CLKSRC_OFS) begin
      for (int p = 0; p < 3; p++) begin
        rdVal[`PCC_SRC_STRIDE * p +: 3] = srcSelQ[p];
      end
    end
    if (addr == `PCC_OUT_OFS) begin
      rdVal[`PCC_POL_LSB +: 6] = polQ;
      rdVal[`PCC_MSKEN_LSB +: 6] = mskEnQ;
      rdVal[`PCC_MSKDAT_LSB +: 6] = mskDatQ;
      rdVal[`PCC_OE_LSB +: 6] = oeQ;
      rdVal[`PCC_BRAKEEN_BIT] = brakeEnQ;
    end
    if (addr == `PCC_CAPCTL_OFS) begin
      rdVal[`PCC_CAPEN_LSB +: 6] = capEnQ;
      rdVal[`PCC_CAPRISE_LSB +: 6] = capRiseQ;
      rdVal[`PCC_CAPFALL_LSB +: 6] = capFallQ;
    end
    if (addr == `PCC_TRIG_OFS) begin
      rdVal = {adcEnQ, trigEnQ};
    end
    for (int p = 0; p < 3; p++) begin
      if (addr == 8'(`PCC_PSC_BASE + 4 * p)) begin
        rdVal[11:0] = pscValQ[p];
      end
      if (addr == 8'(`PCC_PER_BASE + 4 * p)) begin
        rdVal[15:0] = perShQ[p];
      end
      if (addr == 8'(`PCC_CNT_BASE + 4 * p)) begin
        rdVal[15:0] = cntQ[p];
        rdVal[`PCC_DIR_BIT] = dirQ[p];
      end
    end
    for (int c = 0; c < 6; c++) begin
      if (addr == 8'(`PCC_CMP_BASE + 4 * c)) begin
        rdVal[15:0] = cmpShQ[c];
      end
      if (addr == 8'(`PCC_CAP_BASE + 4 * c)) begin
        rdVal[15:0] = capQ[c];
      end
    end
  end

  // Read data is held only for the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData <= 32'h0000_0000;
    end else begin
      rdData <= rdEn ? rdVal : 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// ---- verification/pcc_core_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcc_core_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [31:0] rdData,
  input wire logic brakeIn,
  input wire logic [5:0] pwmOut,
  input wire logic [5:0] pwmOe,
  input wire logic [5:0] cmpUpEvt,
  input wire logic [5:0] cmpDnEvt,
  input wire pcc_pkg::pcc_pair_evt_t [2:0] pairEvt,
  input wire logic [2:0] intReq,
  input wire logic [2:0] adcTrig
);
  logic [31:0] ctrl_q;
  logic [31:0] out_q;
  logic [31:0] trig_q;
  logic [31:0] trigPrev_q;
  logic intExp;
  logic adcExp;
  logic [1:0] cmpAny;
  logic midEvt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  assign cmpAny = cmpUpEvt[1:0] | cmpDnEvt[1:0];
  assign midEvt = pairEvt[0].period | pairEvt[0].center;
  // Shadow copies of the routing registers keep the checker on the ports alone.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= 32'h0;
      out_q <= 32'h0;
      trig_q <= 32'h0;
    end else if (wrEn) begin
      case (addr)
        8'h00: ctrl_q <= wrData;
        8'h48: out_q <= wrData;
        8'h68: trig_q <= wrData;
        default: ;
      endcase
    end
  end
  // The request pulse stands beside the event pulse, so it follows the enables of the cycle before.
  always_ff @(posedge clk) begin
    trigPrev_q <= trig_q;
  end
  assign intExp = trigPrev_q[0] & pairEvt[0].zero | trigPrev_q[4] & midEvt | |(trigPrev_q[9:8] & cmpAny);
  assign adcExp = trigPrev_q[16] & pairEvt[0].zero | trigPrev_q[20] & midEvt | |(trigPrev_q[25:24] & cmpAny);
  property p_rd_idle; !$past(rdEn) |-> rdData == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_cnt_top; rdEn && addr == 8'h20 |=> rdData[31:17] == 15'h0; endproperty
  a_cnt_top: assert property (p_cnt_top) else $error("counter word upper bits set");
  property p_int; intReq[0] == intExp; endproperty
  a_int: assert property (p_int) else $error("interrupt routing wrong");
  property p_adc; adcTrig[0] == adcExp; endproperty
  a_adc: assert property (p_adc) else $error("converter trigger routing wrong");
  property p_brake; brakeIn && out_q[30] |=> pwmOe == 6'h0 && pwmOut == 6'h0; endproperty
  a_brake: assert property (p_brake) else $error("outputs live while braking");
  property p_oe; !$past(out_q[30]) |-> pwmOe == $past(out_q[29:24]); endproperty
  a_oe: assert property (p_oe) else $error("output enable mismatch");
  property p_mid; !(pairEvt[0].period && pairEvt[0].center); endproperty
  a_mid: assert property (p_mid) else $error("period and center together");
  property p_off; !ctrl_q[0] ##1 !ctrl_q[0] |=> pairEvt[0] == 3'h0 && cmpAny == 2'h0; endproperty
  a_off: assert property (p_off) else $error("event from disabled pair");
  property p_comp; ctrl_q[12] ##1 ctrl_q[12] |=> cmpUpEvt[0] == cmpUpEvt[1] && cmpDnEvt[0] == cmpDnEvt[1];
  endproperty
  a_comp: assert property (p_comp) else $error("even channel not on odd comparator");
  c_zero: cover property (pairEvt[0].zero);
  c_center: cover property (pairEvt[0].center);
  c_brake: cover property (brakeIn && out_q[30]);
endmodule
bind pwm_counter_compare_core pcc_core_sva pcc_core_sva_i (
  .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
  .brakeIn(brakeIn), .pwmOut(pwmOut), .pwmOe(pwmOe), .cmpUpEvt(cmpUpEvt), .cmpDnEvt(cmpDnEvt),
  .pairEvt(pairEvt), .intReq(intReq), .adcTrig(adcTrig)
);
`default_nettype wire

// ---- verification/pcc_stage_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcc_stage_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] adcTrig,
  input wire logic tripCmd,
  output logic brakeIn,
  output logic [15:0] convCount
);
  logic trip_q;
  logic [15:0] count_q;
  // The stage trips through a registered comparator, so the fault lags its cause by a clock.
  always_ff @(posedge clk) begin
    if (rst) begin
      trip_q <= 1'b0;
    end else begin
      trip_q <= tripCmd;
    end
  end
  assign brakeIn = trip_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= 16'h0;
    end else begin
      count_q <= count_q + 16'(adcTrig[0]) + 16'(adcTrig[1]) + 16'(adcTrig[2]);
    end
  end
  assign convCount = count_q;
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [2:0] src;
    logic ratio;
    logic [1:0] ctype;
    logic [11:0] psc;
    logic [15:0] per;
    logic [15:0] cmp;
    int len;
    int nCmp;
  } pcc_row_t;
  pcc_row_t rows [8] = '{
    '{3'h0, 1'b0, pcc_pkg::PCC_UP, 12'h0, 16'h5, 16'h2, 6, 1},
    '{3'h0, 1'b0, pcc_pkg::PCC_UP, 12'h2, 16'h3, 16'h1, 12, 1},
    '{3'h0, 1'b0, pcc_pkg::PCC_DOWN, 12'h0, 16'h4, 16'h2, 5, 1},
    '{3'h0, 1'b0, pcc_pkg::PCC_UPDOWN, 12'h0, 16'h4, 16'h2, 8, 2},
    '{3'h0, 1'b0, pcc_pkg::PCC_UPDOWN, 12'h1, 16'h3, 16'h1, 12, 2},
    '{3'h0, 1'b1, pcc_pkg::PCC_UP, 12'h0, 16'h3, 16'h1, 8, 1},
    '{3'h1, 1'b0, pcc_pkg::PCC_UP, 12'h0, 16'h2, 16'h1, 9, 1},
    '{3'h0, 1'b0, pcc_pkg::PCC_UP, 12'hfff, 16'h1, 16'h0, 8192, 1}
  };
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h0;
  logic [31:0] wrData = 32'h0;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic [3:0] timerTrig = 4'h0;
  logic [5:0] capIn = 6'h0;
  logic tripCmd = 1'b0;
  logic [1:0] tick_q = 2'h0;
  logic [31:0] rdData;
  logic brakeIn;
  logic [5:0] pwmOut;
  logic [5:0] pwmOe;
  logic [5:0] cmpUpEvt;
  logic [5:0] cmpDnEvt;
  pcc_pkg::pcc_pair_evt_t [2:0] pairEvt;
  logic [2:0] intReq;
  logic [2:0] adcTrig;
  logic [15:0] convCount;
  int mismatches = 0;
  int samplesChecked = 0;
  int len;
  int nCmp;
  int nMid;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    tick_q <= (tick_q == 2'h2) ? 2'h0 : tick_q + 2'h1;
    timerTrig[0] <= (tick_q == 2'h0);
  end
  pwm_counter_compare_core pwm_counter_compare_core_i (
    .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .timerTrig(timerTrig), .capIn(capIn), .brakeIn(brakeIn), .pwmOut(pwmOut), .pwmOe(pwmOe),
    .cmpUpEvt(cmpUpEvt), .cmpDnEvt(cmpDnEvt), .pairEvt(pairEvt), .intReq(intReq), .adcTrig(adcTrig)
  );
  pcc_stage_model pcc_stage_model_i (
    .clk(clk), .rst(rst), .adcTrig(adcTrig), .tripCmd(tripCmd), .brakeIn(brakeIn), .convCount(convCount)
  );
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    @(negedge clk);
    chk(rdData, e);
    @(posedge clk);
  endtask
  // Counts clocks up to the next zero event; the bound also catches a stalled counter.
  task automatic measure();
    len = 0;
    nCmp = 0;
    nMid = 0;
    do begin
      @(posedge clk);
      len++;
      nCmp += cmpUpEvt[0] + cmpDnEvt[0];
      nMid += pairEvt[0].period | pairEvt[0].center;
    end while (pairEvt[0].zero !== 1'b1 && len < 20000);
    if (len >= 20000) begin
      mismatches++;
      end_of_test();
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(8'h68, 32'h10001);
    foreach (rows[i]) begin
      wr(8'h00, 32'h0);
      wr(8'h04, {29'h0, rows[i].src});
      wr(8'h08, {20'h0, rows[i].psc});
      wr(8'h14, {16'h0, rows[i].per});
      wr(8'h30, {16'h0, rows[i].cmp});
      wr(8'h00, {15'h0, rows[i].ratio, 10'h0, rows[i].ctype, 4'h1});
      measure();
      measure();
      chk(len, rows[i].len);
      chk(nCmp, rows[i].nCmp);
      chk(nMid, 32'h1);
      $display("row %0d done", i);
    end
    chk(convCount != 16'h0, 32'h1);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h14, 32'hffff);
    rd(8'h30, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h20, 32'h10000);
    rd(8'hfc, 32'h0);
    $display("reset test done");
    wr(8'h00, 32'h10);
    wr(8'h14, 32'h1234);
    rd(8'h20, 32'h1234);
    wr(8'h4c, 32'h101);
    capIn <= 6'h1;
    repeat (3) @(posedge clk);
    rd(8'h50, 32'h1234);
    $display("capture test done");
    wr(8'h14, 32'h9);
    wr(8'h00, 32'h1);
    measure();
    wr(8'h14, 32'h3);
    measure();
    // The two bus cycles of the write fall inside this ten-clock period.
    chk(len, 32'h8);
    measure();
    chk(len, 32'h4);
    $display("reload test done");
    wr(8'h34, 32'h2);
    wr(8'h30, 32'h7);
    wr(8'h00, 32'h1001);
    measure();
    measure();
    chk(nCmp, 32'h1);
    $display("complementary test done");
    wr(8'h48, 32'h7f3f3f00);
    repeat (2) @(posedge clk);
    chk(pwmOe, 32'h3f);
    chk(pwmOut, 32'h3f);
    tripCmd <= 1'b1;
    repeat (3) @(posedge clk);
    chk(pwmOe, 32'h0);
    chk(pwmOut, 32'h0);
    tripCmd <= 1'b0;
    $display("brake test done");
    end_of_test();
  end
endmodule
`default_nettype wire
